// [core/cdm_pkg.sv]
// package for the clock divisor and module disable block
// assumes a 32-bit axi4-lite register bus on one clock domain
package cdm_pkg;
    // ********************************************************
    // register map
    // ********************************************************
    localparam logic [3:0] CDM_ADDR_DIVCTL = 4'h0;
    localparam logic [3:0] CDM_ADDR_PMD = 4'h4;
    localparam logic [15:0] CDM_DIVCTL_RST = 16'h3040;
    localparam logic [15:0] CDM_PMD_RST = 16'h0000;
    localparam logic [15:0] CDM_DIVCTL_MASK = 16'hFFDF;
    localparam logic [15:0] CDM_PMD_MASK = 16'hFEFB;
    localparam int CDM_WAKE_BIT = 15;
    localparam int CDM_REDUCE_EN_BIT = 11;
    localparam logic [2:0] CDM_RATIO_NONE = 3'h0;
    localparam logic [1:0] CDM_POST_RSVD = 2'h2;
    localparam logic [1:0] CDM_RESP_OKAY = 2'h0;
    localparam logic [1:0] CDM_RESP_SLVERR = 2'h2;

    // ********************************************************
    // field carrier
    // ********************************************************
    typedef struct packed {
        logic return_on_interrupt;
        logic [2:0] ratio;
        logic reduction_enable;
        logic [2:0] rc_osc_postscale;
        logic [1:0] pll_output_divider;
        logic unused5;
        logic [4:0] pll_input_divider;
    } cdm_divctl_s;

    typedef struct packed {
        logic [7:0] log2_div;
        logic [7:0] count_max;
    } cdm_div_s;
endpackage

// [core/cdm_clock_divisor.sv]
// clock divisor and peripheral module disable, axi4-lite slave
// assumes one clock aclk, interrupt pulse from the same domain
`timescale 1ns/10ps
module cdm_clock_divisor #(
    parameter int RATIO_W = 3
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic irq_event,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output cdm_pkg::cdm_div_s rc_div,
    output cdm_pkg::cdm_div_s pll_post_div,
    output logic pll_post_invalid,
    output logic [4:0] pll_pre_divisor,
    output logic [15:0] periph_off
);
    import cdm_pkg::*;

    // elaboration check: the field carrier is fixed at three ratio bits
    if (RATIO_W != 3) begin : g_ratio_check
        $error("ratio field must be 3 bits");
    end

    // ********************************************************
    // register state
    // ********************************************************
    cdm_divctl_s divctl_q, divctl_d;
    logic [15:0] pmd_q, pmd_d;
    logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
    logic [3:0] awaddr_q, awaddr_d;
    logic [15:0] wdata_q, wdata_d;
    logic [1:0] wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [15:0] rdata_q, rdata_d;
    logic [6:0] doze_cnt_q, doze_cnt_d;
    logic cpu_en_q, cpu_en_d;
    logic [6:0] doze_max;
    logic do_write;
    logic [15:0] wmerge;
    cdm_divctl_s wr_cd;

    assign doze_max = 7'((8'h01 << divctl_q.ratio) - 8'h01);

    // write channel capture and register update
    always_comb begin
        aw_hold_d = aw_hold_q;
        w_hold_d = w_hold_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        divctl_d = divctl_q;
        pmd_d = pmd_q;
        wmerge = 16'h0000;
        wr_cd = divctl_q;
        if (s_axi_awvalid && !aw_hold_q) begin
            aw_hold_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_hold_q) begin
            w_hold_d = 1'b1;
            wdata_d = s_axi_wdata[15:0];
            wstrb_d = s_axi_wstrb[1:0];
        end
        do_write = aw_hold_q && w_hold_q && !bvalid_q;
        if (do_write) begin
            aw_hold_d = 1'b0;
            w_hold_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = CDM_RESP_OKAY;
            if (awaddr_q == CDM_ADDR_DIVCTL) begin
                wmerge[7:0] = wstrb_q[0] ? wdata_q[7:0] : divctl_q[7:0];
                wmerge[15:8] = wstrb_q[1] ? wdata_q[15:8] : divctl_q[15:8];
                wr_cd = cdm_divctl_s'(wmerge & CDM_DIVCTL_MASK);
                if (divctl_q.reduction_enable) begin
                    wr_cd.ratio = divctl_q.ratio;
                end
                if (wr_cd.reduction_enable && !divctl_q.reduction_enable
                    && divctl_q.ratio == CDM_RATIO_NONE) begin
                    wr_cd.reduction_enable = 1'b0;
                end
                divctl_d = wr_cd;
            end else if (awaddr_q == CDM_ADDR_PMD) begin
                wmerge[7:0] = wstrb_q[0] ? wdata_q[7:0] : pmd_q[7:0];
                wmerge[15:8] = wstrb_q[1] ? wdata_q[15:8] : pmd_q[15:8];
                pmd_d = wmerge & CDM_PMD_MASK;
            end else begin
                bresp_d = CDM_RESP_SLVERR;
            end
        end
        // interrupt wins over a concurrent software write
        if (irq_event && divctl_q.return_on_interrupt) begin
            divctl_d.reduction_enable = 1'b0;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
    end

    // read channel, one read outstanding
    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_axi_arvalid && !rvalid_q) begin
            rvalid_d = 1'b1;
            rresp_d = CDM_RESP_OKAY;
            if (s_axi_araddr == CDM_ADDR_DIVCTL) begin
                rdata_d = divctl_q;
            end else if (s_axi_araddr == CDM_ADDR_PMD) begin
                rdata_d = pmd_q;
            end else begin
                rdata_d = 16'h0000;
                rresp_d = CDM_RESP_SLVERR;
            end
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    // doze divider: cpu enable every 2^ratio peripheral cycles
    // counter parks at one while doze is off, so entry skips a cycle instead of giving two enables in a row
    always_comb begin
        doze_cnt_d = doze_cnt_q;
        cpu_en_d = 1'b1;
        if (divctl_q.reduction_enable) begin
            cpu_en_d = (doze_cnt_q == 7'h00);
            doze_cnt_d = (doze_cnt_q >= doze_max) ? 7'h00 : doze_cnt_q + 7'h01;
        end else begin
            doze_cnt_d = 7'h01;
        end
    end

    // ********************************************************
    // registers
    // ********************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            divctl_q <= cdm_divctl_s'(CDM_DIVCTL_RST);
            pmd_q <= CDM_PMD_RST;
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 16'h0000;
            wstrb_q <= 2'h0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            rvalid_q <= 1'b0;
            rresp_q <= 2'h0;
            rdata_q <= 16'h0000;
            doze_cnt_q <= 7'h01;
            cpu_en_q <= 1'b1;
        end else begin
            divctl_q <= divctl_d;
            pmd_q <= pmd_d;
            aw_hold_q <= aw_hold_d;
            w_hold_q <= w_hold_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            doze_cnt_q <= doze_cnt_d;
            cpu_en_q <= cpu_en_d;
        end
    end

    // divider settings, straight from registers except periph_clk_en, which is tied high
    assign s_axi_awready = !aw_hold_q;
    assign s_axi_wready = !w_hold_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = {16'h0000, rdata_q};
    assign cpu_clk_en = cpu_en_q;
    assign periph_clk_en = 1'b1; // peripheral clock is aclk itself
    assign rc_div.log2_div = {5'h00, divctl_q.rc_osc_postscale};
    assign rc_div.count_max = 8'((9'h001 << divctl_q.rc_osc_postscale) - 9'h001);
    // 00 div 2, 01 div 4, 11 div 8, 10 reserved
    assign pll_post_div.log2_div = divctl_q.pll_output_divider == 2'h3 ? 8'h03 :
                                   divctl_q.pll_output_divider == 2'h1 ? 8'h02 : 8'h01;
    assign pll_post_div.count_max = (8'h01 << pll_post_div.log2_div) - 8'h01;
    assign pll_post_invalid = (divctl_q.pll_output_divider == CDM_POST_RSVD);
    assign pll_pre_divisor = divctl_q.pll_input_divider; // divisor is value plus two
    assign periph_off = pmd_q;

    // ********************************************************
    // checks
    // ********************************************************
    a_wake_clears: assert property (@(posedge aclk) disable iff (!aresetn)
        irq_event && divctl_q.return_on_interrupt |=> !divctl_q.reduction_enable) else $error("wake clear lost");
    a_no_wake_keep: assert property (@(posedge aclk) disable iff (!aresetn)
        irq_event && !divctl_q.return_on_interrupt && divctl_q.reduction_enable && !do_write
        |=> divctl_q.reduction_enable) else $error("doze cleared without wake bit");
    a_doze_zero_block: assert property (@(posedge aclk) disable iff (!aresetn)
        !divctl_q.reduction_enable && divctl_q.ratio == 3'h0 |=> !divctl_q.reduction_enable)
        else $error("doze set at ratio zero");
    a_ratio_locked: assert property (@(posedge aclk) disable iff (!aresetn)
        divctl_q.reduction_enable |=> $stable(divctl_q.ratio)) else $error("ratio changed in doze");
    a_full_rate: assert property (@(posedge aclk) disable iff (!aresetn)
        !divctl_q.reduction_enable |=> cpu_clk_en) else $error("cpu slowed without doze");
    a_div2_pattern: assert property (@(posedge aclk) disable iff (!aresetn)
        divctl_q.reduction_enable && divctl_q.ratio == 3'h1 && cpu_clk_en
        ##1 divctl_q.reduction_enable |-> !cpu_clk_en) else $error("div 2 pattern wrong");
    a_rsvd_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        pll_post_invalid == (divctl_q.pll_output_divider == 2'h2)) else $error("reserved flag wrong");
    a_pmd_hole: assert property (@(posedge aclk) disable iff (!aresetn)
        periph_off[8] == 1'b0 && periph_off[2] == 1'b0) else $error("unimplemented disable bit set");
    c_doze_on: cover property (@(posedge aclk) disable iff (!aresetn) $rose(divctl_q.reduction_enable));
    c_irq_wake: cover property (@(posedge aclk) disable iff (!aresetn)
        $fell(divctl_q.reduction_enable) && $past(irq_event));
    c_div128: cover property (@(posedge aclk) disable iff (!aresetn)
        divctl_q.reduction_enable && divctl_q.ratio == 3'h7);
    c_div2: cover property (@(posedge aclk) disable iff (!aresetn)
        divctl_q.reduction_enable && divctl_q.ratio == 3'h1);
endmodule // cdm_clock_divisor

// [testbench/testbench.sv]
// self-checking bench for the clock divisor and module disable block
// assumes cdm_pkg and cdm_clock_divisor compiled first, one 100 MHz clock
`timescale 1ns/10ps
module testbench;
    import cdm_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, irq, awready, wready, bvalid, arready, rvalid;
    logic cpu_en, per_en, post_bad;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, v;
    logic [1:0] bresp, rresp, rsp;
    logic [4:0] pre;
    logic [15:0] off;
    cdm_div_s rc, post;
    int n_fail, n_tests, c;
    cdm_clock_divisor DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_event(irq),
        .cpu_clk_en(cpu_en), .periph_clk_en(per_en), .rc_div(rc), .pll_post_div(post),
        .pll_post_invalid(post_bad), .pll_pre_divisor(pre), .periph_off(off));
    // ********************************************************
    // helpers
    // ********************************************************
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // bounded wait; a hang counts as a mismatch and ends the run
    task automatic give_up(input int i);
        if (i >= 50) begin
            $display("mismatch bus answer expected within %0d seen %0d", 50, i);
            n_fail++;
            final_report;
        end
    endtask
    // address and data offered together, each released once taken
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        int i;
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        give_up(i);
        rsp = bresp;
    endtask
    task automatic rd(input logic [3:0] a);
        int i;
        araddr <= a; arvalid <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        give_up(i);
        v = rdata; rsp = rresp;
    endtask
    // interrupt pulse, then a few cycles for the register to settle
    task automatic pulse_irq;
        irq <= 1'b1;
        @(posedge aclk);
        irq <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask
    task automatic count_en(input int n);
        c = 0;
        repeat (n) begin
            @(posedge aclk);
            if (cpu_en === 1'b1) c++;
        end
    endtask
    // ********************************************************
    // main sequence
    // ********************************************************
    initial begin
        n_fail = 0; n_tests = 0;
        // response readies stay high all run, so back-to-back calls never drive them twice in one step
        aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b1; arvalid = 1'b0; rready = 1'b1;
        irq = 1'b0; awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0; wstrb = 4'hF;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(4'h0); chk("divctl reset", v, 32'h00003040);
        rd(4'h4); chk("disable reset", v, 32'h0);
        chk("rc reset", rc.log2_div, 32'h0);
        chk("post reset", post.log2_div, 32'h2);
        chk("pre reset", pre, 32'h0);
        $display("test reset done");
        // doze refused with ratio 000; cpu runs every cycle
        wr(4'h0, 32'h0040); wr(4'h0, 32'h0840);
        rd(4'h0); chk("doze at 000", v, 32'h00000040);
        count_en(64); chk("cpu en full", c, 32'd64);
        chk("periph en", per_en, 32'h1);
        $display("test refuse done");
        wr(4'h0, 32'h3040); wr(4'h0, 32'h3840);
        count_en(64); chk("cpu en div8", c, 32'd8);
        wr(4'h0, 32'h5840);
        rd(4'h0); chk("ratio locked", v, 32'h00003840);
        pulse_irq;
        rd(4'h0); chk("irq no wake", v, 32'h00003840);
        wr(4'h0, 32'hB840); pulse_irq;
        rd(4'h0); chk("irq wake", v, 32'h0000B040);
        $display("test doze done");
        wr(4'h0, 32'h7040); wr(4'h0, 32'h7840);
        count_en(256); chk("cpu en div128", c, 32'd2);
        wr(4'h0, 32'h7040);
        // ratio 1:2 alternates cpu enable from the first doze cycle
        wr(4'h0, 32'h1040);
        wr(4'h0, 32'h1840);
        count_en(64);
        chk("cpu en div2", c, 32'd32);
        // every postscaler and output divider code, input divider codes 0 to 21 in steps of three
        for (int k = 0; k < 8; k++) begin
            wr(4'h0, {16'h0, 5'h0, 3'(k), 2'(k), 1'b0, 5'(k * 3)});
            chk("rc log2", rc.log2_div, k);
            chk("rc count", rc.count_max, (1 << k) - 1);
            chk("post count", post.count_max, (k % 4 == 3) ? 7 : (k % 4 == 1) ? 3 : 1);
            chk("post log2", post.log2_div, (k % 4 == 3) ? 3 : (k % 4 == 1) ? 2 : 1);
            chk("post bad", post_bad, k % 4 == 2);
            chk("pre", pre, k * 3);
        end
        $display("test dividers done");
        wr(4'h4, 32'hFFFF);
        rd(4'h4); chk("disable rd", v, 32'h0000FEFB);
        chk("disable out", off, 32'h0000FEFB);
        wr(4'h4, 32'h8410); chk("disable mix", off, 32'h00008410);
        wr(4'h8, 32'h1); chk("wr unmapped", rsp, 32'h2);
        rd(4'h8); chk("rd unmapped", rsp, 32'h2);
        chk("rd unmapped data", v, 32'h0);
        $display("test map done");
        // mid-run reset brings both registers back to their reset values
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(4'h0);
        chk("divctl reset again", v, 32'h00003040);
        chk("disable reset again", off, 32'h0);
        $display("test reset again done");
        final_report;
    end
endmodule // testbench
